// file: hdl/spi_core_pkg.sv
package spi_core_pkg;

    // Main control bit positions
    localparam int GO_BIT        = 0;
    localparam int SAMPLE_NEG    = 1;
    localparam int LAUNCH_NEG    = 2;
    localparam int LEN_LSB       = 3;
    localparam int LEN_MSB       = 7;
    localparam int LSB_FIRST_BIT = 10;
    localparam int IDLE_POL_BIT  = 11;
    localparam int SUSP_LSB      = 12;
    localparam int SUSP_MSB      = 15;
    localparam int SLAVE_BIT     = 18;
    localparam int VARIABLE_CLOCK_PATTERN_BIT    = 23;

    // Select control bit positions
    localparam int SEL_EN_LSB    = 0;
    localparam int SEL_EN_MSB    = 1;
    localparam int SEL_LVL_BIT   = 2;
    localparam int SEL_AUTO_BIT  = 3;
    localparam int SEL_LTRIG_BIT = 4;

    // Pattern layout
    localparam int PAT_FIRST_BIT = 31;

    // Suspend below this keeps the select active between words
    localparam logic [3:0] SUSP_KEEP_LIMIT = 4'h3;
    localparam logic [3:0] SUSP_RESET      = 4'h3;

    // Word length code zero means 32 bits
    localparam logic [5:0] FULL_WORD = 6'h20;

    // Least select gap in engine clock periods (other party)
    localparam int SEL_GAP_ENGINE = 6;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_XFER,
        ST_SUSPEND
    } xfer_state_e;

    typedef struct packed {
        logic sclk;
        logic mosi;
        logic sel0;
        logic sel1;
    } master_pins_s;

    typedef struct packed {
        logic       done;
        logic       busy;
        logic       level_trigger_complete_flag;
        logic [5:0] bit_count;
    } core_status_s;

endpackage : spi_core_pkg

// file: hdl/spi_master_slave_core.sv
// What this block does
// (R1) Engine clock comes from bus clock or PLL, scaled by a divider.
// (R2) Master without variable pattern: serial clock runs at half the engine rate.
// (R3) As slave, the outside master clocks slower than our engine clock.
// (R4) Control bit 18 picks master or slave operation.
// (R5) Master drives two selects; slave takes select from select line zero.
// (R6) Select bit 2 sets active level; bit 4 picks level or edge trigger.
// (R7) Slave edge mode: word starts on active edge, ends only on inactive.
// (R8) Slave level mode: word ends, done set, when bit count reaches length.
// (R9) Slave level mode: select going inactive ends word at once, sets done.
// (R10) Select status bit 5 shows last level-mode word met the length.
// (R11) Master auto select asserts enabled lines on go, releases at finish.
// (R12) Manual select: outputs follow enable bits at programmed active level.
// (R13) Auto select with suspend below 3 keeps select active between words.
// (R14) Outside master holds select inactive six engine clocks between words.
// (R15) Variable enable bit 23 shapes each clock period from the pattern.
// (R16) Software sets length 16 when the variable pattern is used.
// (R17) Pattern bit 31 picks first cycle's divider: primary or second.
// (R18) Pattern bit pairs 30:1 define later cycles; bit 0 ignored.
// (R19) Bit 11 sets serial clock idle level.
// (R20) Length field bits 7:3 set bits per word, up to 32.
// (R21) Bit 10 set sends bit 0 first, else MSB first.
// (R22) Bit 2 picks slave launch edge (master launches on each cycle's second edge), bit 1 sample edge.
// (R23) Go/busy clears by hardware when the word completes.
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_core (
    input  wire logic                        clk_sys,
    input  wire logic                        rst_b,
    input  wire logic                        pll_clk_en,
    input  wire logic                        engine_clock_source_bit,
    input  wire logic [7:0]                  clock_divider,
    input  wire logic [7:0]                  second_clock_divider,
    input  wire logic [31:0]                 main_control_register,
    input  wire logic                        go_set,
    input  wire logic [4:0]                  select_control_register,
    input  wire logic [31:0]                 variable_clock_pattern_register,
    input  wire logic [31:0]                 tx_word,
    input  wire logic                        sclk_in,
    input  wire logic                        select_line_zero_in,
    input  wire logic                        mosi_in,
    input  wire logic                        miso_in,
    output var spi_core_pkg::master_pins_s   master_pins,
    output logic                             miso_out,
    output logic                             miso_oe,
    output logic [31:0]                      rx_word,
    output var spi_core_pkg::core_status_s   status
);
    logic [31:0] ctl;
    logic        slave_mode, lsb_first, idle_pol, launch_neg, sample_neg, var_en;
    logic        act_lvl, auto_sel, ltrig;
    logic [5:0]  word_len;
    logic [3:0]  susp;
    assign ctl        = main_control_register;
    assign slave_mode = ctl[spi_core_pkg::SLAVE_BIT];                              // R4
    assign lsb_first  = ctl[spi_core_pkg::LSB_FIRST_BIT];                          // R21
    assign idle_pol   = ctl[spi_core_pkg::IDLE_POL_BIT];                           // R19
    assign launch_neg = ctl[spi_core_pkg::LAUNCH_NEG];                             // R22
    assign sample_neg = ctl[spi_core_pkg::SAMPLE_NEG];                             // R22
    assign var_en     = ctl[spi_core_pkg::VARIABLE_CLOCK_PATTERN_BIT];                             // R15
    assign susp       = ctl[spi_core_pkg::SUSP_MSB:spi_core_pkg::SUSP_LSB];
    assign act_lvl    = select_control_register[spi_core_pkg::SEL_LVL_BIT];        // R6
    assign auto_sel   = select_control_register[spi_core_pkg::SEL_AUTO_BIT];
    assign ltrig      = select_control_register[spi_core_pkg::SEL_LTRIG_BIT];      // R6
    // Length code zero stands for 32
    assign word_len   = (ctl[spi_core_pkg::LEN_MSB:spi_core_pkg::LEN_LSB] == 5'h00) ?
                        spi_core_pkg::FULL_WORD :
                        {1'b0, ctl[spi_core_pkg::LEN_MSB:spi_core_pkg::LEN_LSB]};  // R20

    // Engine tick: source gate then divider
    logic       src_tick;
    logic [7:0] div_cnt_reg;
    logic [7:0] div_sel;
    logic       eng_tick;
    logic       use_second;
    assign src_tick = engine_clock_source_bit ? pll_clk_en : 1'b1;                 // R1
    assign div_sel  = use_second ? second_clock_divider : clock_divider;           // R17
    assign eng_tick = src_tick && (div_cnt_reg >= div_sel);
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt_reg <= 8'h00;
        end else if (src_tick) begin
            div_cnt_reg <= eng_tick ? 8'h00 : div_cnt_reg + 8'h01;                 // R1
        end
    end

    // Master sequencer: one engine tick per half serial clock
    spi_core_pkg::xfer_state_e state_reg;
    logic        sclk_reg, half_reg, done_reg, busy_reg;
    logic [5:0]  bits_reg;
    logic [4:0]  pat_idx_reg;
    logic [4:0]  susp_cnt_reg;
    logic [31:0] shift_tx_reg, shift_rx_reg;
    logic        mosi_reg;
    logic [1:0]  pat_pair;
    logic        lead_edge_neg;

    // Second divider for the first cycle when pattern bit 31 is set, or for a later pattern pair with its high bit set
    assign pat_pair   = variable_clock_pattern_register[pat_idx_reg +: 2];
    assign use_second = var_en && !slave_mode && (state_reg == spi_core_pkg::ST_XFER) &&
                        ((bits_reg == 6'h00) ? variable_clock_pattern_register[spi_core_pkg::PAT_FIRST_BIT]
                                             : pat_pair[1]);                      // R15 R17 R18
    // Edge leaving idle is rising when idle low
    assign lead_edge_neg = idle_pol;

    logic [31:0] tx_aligned;
    assign tx_aligned = lsb_first ? tx_word : (tx_word << (6'd32 - word_len));    // R21

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg    <= spi_core_pkg::ST_IDLE;
            sclk_reg     <= 1'b0;
            half_reg     <= 1'b0;
            bits_reg     <= 6'h00;
            pat_idx_reg  <= 5'h1d;
            susp_cnt_reg <= 5'h00;
            busy_reg     <= 1'b0;
            done_reg     <= 1'b0;
            shift_tx_reg <= 32'h0000_0000;
            shift_rx_reg <= 32'h0000_0000;
            mosi_reg     <= 1'b0;
        end else if (!slave_mode) begin
            done_reg <= 1'b0;
            case (state_reg)
                spi_core_pkg::ST_IDLE: begin
                    sclk_reg <= idle_pol;                                          // R19
                    if (go_set) begin
                        busy_reg     <= 1'b1;
                        state_reg    <= spi_core_pkg::ST_XFER;
                        bits_reg     <= 6'h00;
                        half_reg     <= 1'b0;
                        pat_idx_reg  <= 5'h1d;
                        shift_tx_reg <= tx_aligned;
                        // Launch first bit now, whichever launch edge is chosen
                        mosi_reg     <= lsb_first ? tx_aligned[0] : tx_aligned[31];
                    end
                end
                spi_core_pkg::ST_XFER: begin
                    if (eng_tick) begin                                            // R2
                        sclk_reg <= ~sclk_reg;
                        half_reg <= ~half_reg;
                        // Sample on the chosen edge
                        if ((sclk_reg ? 1'b1 : 1'b0) == sample_neg) begin          // R22
                            shift_rx_reg <= lsb_first ? {miso_in, shift_rx_reg[31:1]}
                                                      : {shift_rx_reg[30:0], miso_in};
                        end
                        if (half_reg) begin
                            bits_reg <= bits_reg + 6'h01;
                            if (bits_reg != 6'h00) begin
                                pat_idx_reg <= pat_idx_reg - 5'h02;                // R18
                            end
                            shift_tx_reg <= lsb_first ? {1'b0, shift_tx_reg[31:1]}
                                                      : {shift_tx_reg[30:0], 1'b0};
                            if (bits_reg + 6'h01 == word_len) begin
                                // Done rises as busy ends, one pulse per word
                                state_reg    <= spi_core_pkg::ST_SUSPEND;
                                done_reg     <= 1'b1;
                                busy_reg     <= 1'b0;                              // R23
                                susp_cnt_reg <= {1'b0, susp};
                            end else begin
                                mosi_reg <= lsb_first ? shift_tx_reg[1] : shift_tx_reg[30];
                            end
                        end
                    end
                end
                spi_core_pkg::ST_SUSPEND: begin
                    sclk_reg <= idle_pol;
                    busy_reg <= 1'b0;                                              // R23
                    if (eng_tick) begin
                        if (susp_cnt_reg == 5'h00) begin
                            state_reg <= spi_core_pkg::ST_IDLE;
                        end else begin
                            susp_cnt_reg <= susp_cnt_reg - 5'h01;
                        end
                    end
                    if (go_set) begin
                        busy_reg     <= 1'b1;
                        state_reg    <= spi_core_pkg::ST_XFER;
                        bits_reg     <= 6'h00;
                        half_reg     <= 1'b0;
                        pat_idx_reg  <= 5'h1d;
                        shift_tx_reg <= tx_aligned;
                        mosi_reg     <= lsb_first ? tx_aligned[0] : tx_aligned[31];
                    end
                end
                default: state_reg <= spi_core_pkg::ST_IDLE;
            endcase
        end else begin
            state_reg <= spi_core_pkg::ST_IDLE;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end
    end

    // Master select outputs
    logic        keep_sel;
    logic [1:0]  sel_active;
    logic [1:0]  sel_en;
    assign sel_en   = select_control_register[spi_core_pkg::SEL_EN_MSB:spi_core_pkg::SEL_EN_LSB];
    assign keep_sel = (state_reg == spi_core_pkg::ST_SUSPEND) && (susp < spi_core_pkg::SUSP_KEEP_LIMIT);
    always_comb begin
        if (auto_sel) begin
            sel_active = (busy_reg || keep_sel) ? sel_en : 2'b00;                  // R11 R13
        end else begin
            sel_active = sel_en;                                                   // R12
        end
    end

    // Slave path: serial clock and select sampled in the system clock
    logic        sclk_d_reg, sel_d_reg, sl_active_reg, sl_done_reg, level_trigger_complete_flag_reg;
    logic [5:0]  sl_bits_reg;
    logic [31:0] sl_rx_reg, sl_tx_reg;
    logic        sel_on, sel_rise, sel_fall, sclk_rise, sclk_fall, sl_sample, sl_launch;
    assign sel_on    = (select_line_zero_in == act_lvl);                           // R5 R6
    assign sel_rise  = sel_on && !sel_d_reg;
    assign sel_fall  = !sel_on && sel_d_reg;
    assign sclk_rise = sclk_in && !sclk_d_reg;
    assign sclk_fall = !sclk_in && sclk_d_reg;
    assign sl_sample = sample_neg ? sclk_fall : sclk_rise;                          // R22
    assign sl_launch = launch_neg ? sclk_fall : sclk_rise;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sclk_d_reg     <= 1'b0;
            sel_d_reg      <= 1'b0;
            sl_active_reg  <= 1'b0;
            sl_done_reg    <= 1'b0;
            level_trigger_complete_flag_reg <= 1'b0;
            sl_bits_reg    <= 6'h00;
            sl_rx_reg      <= 32'h0000_0000;
            sl_tx_reg      <= 32'h0000_0000;
        end else begin
            sclk_d_reg  <= sclk_in;
            sel_d_reg   <= sel_on;
            sl_done_reg <= 1'b0;
            if (slave_mode) begin
                if (!sl_active_reg && (ltrig ? sel_on && !sel_d_reg : sel_rise)) begin
                    sl_active_reg <= 1'b1;                                         // R7
                    sl_bits_reg   <= 6'h00;
                    sl_tx_reg     <= tx_aligned;
                end else if (sl_active_reg) begin
                    if (sl_sample && sel_on) begin
                        sl_bits_reg <= sl_bits_reg + 6'h01;
                        sl_rx_reg   <= lsb_first ? {mosi_in, sl_rx_reg[31:1]}
                                                 : {sl_rx_reg[30:0], mosi_in};
                    end
                    if (sl_launch && sel_on && sl_bits_reg != 6'h00) begin
                        sl_tx_reg <= lsb_first ? {1'b0, sl_tx_reg[31:1]}
                                               : {sl_tx_reg[30:0], 1'b0};
                    end
                    if (ltrig) begin
                        if (sl_bits_reg == word_len || !sel_on) begin               // R8 R9
                            sl_active_reg  <= 1'b0;
                            sl_done_reg    <= 1'b1;
                            level_trigger_complete_flag_reg <= (sl_bits_reg == word_len);          // R10
                        end
                    end else if (sel_fall) begin                                   // R7
                        sl_active_reg <= 1'b0;
                        sl_done_reg   <= 1'b1;
                    end
                end
            end else begin
                sl_active_reg <= 1'b0;
            end
        end
    end

    // Received word out of flip-flops
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_word <= 32'h0000_0000;
        end else if (done_reg) begin
            rx_word <= lsb_first ? shift_rx_reg >> (6'd32 - word_len) : shift_rx_reg;
        end else if (sl_done_reg) begin
            rx_word <= lsb_first ? sl_rx_reg >> (6'd32 - sl_bits_reg) : sl_rx_reg;
        end
    end

    assign master_pins.sclk = slave_mode ? idle_pol : sclk_reg;
    assign master_pins.mosi = mosi_reg;
    assign master_pins.sel0 = slave_mode ? ~act_lvl : (sel_active[0] ? act_lvl : ~act_lvl);  // R5
    assign master_pins.sel1 = slave_mode ? ~act_lvl : (sel_active[1] ? act_lvl : ~act_lvl);
    assign miso_out = lsb_first ? sl_tx_reg[0] : sl_tx_reg[31];
    assign miso_oe  = slave_mode && sel_on;
    assign status.done = done_reg || sl_done_reg;
    assign status.busy = busy_reg || sl_active_reg;
    assign status.level_trigger_complete_flag = level_trigger_complete_flag_reg;
    assign status.bit_count = slave_mode ? sl_bits_reg : bits_reg;
    // Idle leading edge kept for reference of launch timing
    logic unused_lead;
    assign unused_lead = lead_edge_neg;
endmodule : spi_master_slave_core
`default_nettype wire

// file: bench/spi_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module spi_core_checker (
    input wire logic                       clk_sys,
    input wire logic                       rst_b,
    input wire logic                       go_set,
    input wire logic                       select_line_zero_in,
    input wire logic                       miso_oe,
    input wire logic [31:0]                main_control_register,
    input wire logic [4:0]                 select_control_register,
    input wire logic [31:0]                rx_word,
    input wire spi_core_pkg::master_pins_s master_pins,
    input wire spi_core_pkg::core_status_s status
);
    logic slv;
    logic lvl;
    logic aut;
    assign slv = main_control_register[18];
    assign lvl = select_control_register[2];
    assign aut = select_control_register[3];
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    sequence s_go;
        go_set && !status.busy && !slv;
    endsequence
    sequence s_idle;
        (!slv && !status.busy && $stable(main_control_register[11]))[*3];
    endsequence
    AST_GO_BUSY: assert property (s_go |=> status.busy)
        else $error("busy not set by go");
    AST_DONE_PULSE: assert property (status.done |=> !status.done)
        else $error("done longer than one cycle");
    AST_BUSY_END: assert property (!slv && $fell(status.busy) |-> ##[0:2] status.done)
        else $error("no done after busy");
    AST_IDLE_POL: assert property (s_idle |-> master_pins.sclk == main_control_register[11])
        else $error("serial clock not at idle level");
    AST_MAN_SEL: assert property (!slv && !aut |->
        master_pins.sel0 == (select_control_register[0] ? lvl : !lvl))
        else $error("manual select wrong");
    AST_AUTO_SEL: assert property (!slv && aut && status.busy && select_control_register[1] |->
        master_pins.sel1 == lvl)
        else $error("auto select not active");
    AST_KEEP_SEL: assert property (!slv && aut && status.done && select_control_register[0] &&
        main_control_register[15:12] < spi_core_pkg::SUSP_KEEP_LIMIT |-> master_pins.sel0 == lvl)
        else $error("select dropped between words");
    AST_RX_HOLD: assert property (!$past(status.done) |-> $stable(rx_word))
        else $error("rx word changed without done");
    AST_OE_SLAVE: assert property ((slv && select_line_zero_in == lvl)[*2] |-> miso_oe)
        else $error("slave output not enabled");
    AST_OE_MASTER: assert property ((!slv)[*2] |-> !miso_oe)
        else $error("slave output enabled as master");
endmodule : spi_core_checker
`default_nettype wire

// file: bench/spi_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
    input  wire logic        sclk,
    input  wire logic        sel_act,
    input  wire logic        lsb,
    input  wire logic [5:0]  len,
    input  wire logic [31:0] word,
    input  wire logic        mosi,
    output logic             miso = 1'b0,
    output logic [31:0]      cap = 32'h0,
    output logic             first = 1'b0
);
    int n = 0;
    always @(posedge sel_act) begin
        n = 0;
        miso = lsb ? word[0] : word[len-1];
    end
    // Launch on falling edge, sample on rising
    always @(negedge sclk) if (sel_act && n < len - 1) begin
        n = n + 1;
        miso = lsb ? word[n] : word[len-1-n];
    end
    // Released line shows the inverse of its last value
    always @(negedge sel_act) miso = ~miso;
    always @(posedge sclk) if (sel_act) begin
        if (n == 0) first = mosi;
        cap = lsb ? {mosi, cap[31:1]} : {cap[30:0], mosi};
    end
endmodule : spi_slave_model
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys = 0, rst_b = 0, pll = 0, src = 0, go_set = 0, sclk_in = 0, ss_in = 1, mosi_in = 0;
    logic [7:0]  div = 8'h01, div2 = 8'h04;
    logic [31:0] ctl = 0, pat = 0, tx = 0, cap, rx, mword = 32'h5a3c_96e1;
    logic [4:0]  select_line_enables = 0;
    logic [5:0]  mlen = 6'h08;
    logic        miso, first, miso_out, miso_oe, sel_act;
    spi_core_pkg::master_pins_s mp;
    spi_core_pkg::core_status_s st;
    int fails = 0, comparisons = 0, dones = 0;
    assign sel_act = (mp.sel0 == select_line_enables[2]);
    initial forever #20 clk_sys = ~clk_sys;
    always @(negedge clk_sys) pll <= ~pll;
    always @(negedge clk_sys) if (st.done === 1'b1) dones++;
    spi_master_slave_core u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .pll_clk_en(pll),
        .engine_clock_source_bit(src), .clock_divider(div), .second_clock_divider(div2),
        .main_control_register(ctl), .go_set(go_set), .select_control_register(select_line_enables),
        .variable_clock_pattern_register(pat), .tx_word(tx), .sclk_in(sclk_in),
        .select_line_zero_in(ss_in), .mosi_in(mosi_in), .miso_in(miso), .master_pins(mp),
        .miso_out(miso_out), .miso_oe(miso_oe), .rx_word(rx), .status(st));
    spi_slave_model u_slave (.sclk(mp.sclk), .sel_act(sel_act), .lsb(ctl[10]), .len(mlen),
        .word(mword), .mosi(mp.mosi), .miso(miso), .cap(cap), .first(first));
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic go;
        @(negedge clk_sys) go_set = 1;
        @(negedge clk_sys) go_set = 0;
    endtask : go
    task automatic wait_dn(input int d0);
        for (int k = 0; k < 400 && dones == d0; k++) @(negedge clk_sys);
    endtask : wait_dn
    task automatic mword_run(input logic lsb, input logic [4:0] lf, input logic [3:0] s, input logic [31:0] d);
        int len, d0;
        logic [31:0] m;
        len = (lf == 0) ? 32 : lf;
        m = (32'h1 << len) - 1;
        @(negedge clk_sys);
        ctl = 32'h4 | (32'(s) << 12) | (32'(lsb) << 10) | (32'(lf) << 3);
        tx = d;
        select_line_enables = 5'h0b;
        mlen = 6'(len);
        d0 = dones;
        go;
        tick(3);
        go;
        wait_dn(d0);
        chk(sel_act, s < 3, "select after word");
        tick(2 * len + 8);
        chk(dones - d0, 1, "done count");
        chk(rx & m, mword & m, "rx word");
        chk(lsb ? cap >> (32 - len) : cap & m, d & m, "mosi word");
        chk(first, lsb ? d[0] : d[len-1], "first bit");
        chk(sel_act, 0, "select released after suspend");
    endtask : mword_run
    task automatic sel_run;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_sys);
            select_line_enables = 5'(i);
            ctl = 32'(i[2]) << 11;
            tick(3);
            chk(mp.sel0, i[0] ? i[2] : !i[2], "sel0");
            chk(mp.sel1, i[1] ? i[2] : !i[2], "sel1");
            chk(mp.sclk, i[2], "idle level");
        end
    endtask : sel_run
    task automatic per_run(input logic s, input logic [31:0] c_in, input logic [31:0] p, input int exp);
        int c, d0;
        @(negedge clk_sys);
        src = s;
        ctl = c_in;
        pat = p;
        select_line_enables = 5'h00;
        d0 = dones;
        go;
        @(posedge mp.sclk);
        c = 0;
        while (mp.sclk === 1'b1 && c < 100) begin
            @(posedge clk_sys);
            #1 c++;
        end
        chk(c, exp, "clock high phase");
        wait_dn(d0);
        tick(4);
    endtask : per_run
    task automatic slave_run(input logic lt, input int n, input logic e1, input logic flag);
        int d0;
        @(negedge clk_sys);
        ctl = 32'h0004_3044;
        select_line_enables = {lt, 4'h0};
        tx = 32'h0000_00c3;
        tick(16);
        d0 = dones;
        ss_in = 0;
        tick(4);
        chk(miso_oe, 1, "slave oe");
        chk(miso_out, 1, "slave first bit");
        for (int k = 0; k < n; k++) begin
            mosi_in = 8'ha5 >> (7 - k);
            tick(6);
            sclk_in = 1;
            tick(6);
            sclk_in = 0;
        end
        tick(8);
        chk(dones - d0, e1, "done after bits");
        chk(st.bit_count, n, "bit count");
        ss_in = 1;
        mosi_in = ~mosi_in;
        tick(16);
        chk(dones - d0, 1, "done total");
        if (lt) chk(st.level_trigger_complete_flag, flag, "length flag");
        if (n == 8) chk(rx[7:0], 8'ha5, "slave rx");
    endtask : slave_run
    task automatic final_report;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    initial begin
        #(40 * 20000);
        fails++;
        final_report;
    end
    initial begin
        tick(2);
        rst_b = 1;
        tick(2);
        mword_run(0, 5'h08, 4'h3, 32'h0000_00b6);
        mword_run(1, 5'h08, 4'h3, 32'h0000_00b6);
        mword_run(0, 5'h00, 4'h3, 32'hc3a5_0f96);
        mword_run(1, 5'h0d, 4'h1, 32'h0000_1e5b);
        sel_run;
        per_run(0, 32'h0000_3044, 32'h0, 2);
        per_run(1, 32'h0000_3044, 32'h0, 4);
        per_run(0, 32'h0080_3084, 32'h8000_0000, 5);
        per_run(0, 32'h0080_3084, 32'h0, 2);
        slave_run(1, 8, 1, 1);
        slave_run(1, 3, 0, 0);
        slave_run(0, 8, 0, 0);
        final_report;
    end
endmodule : testbench
bind spi_master_slave_core spi_core_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .go_set(go_set),
    .select_line_zero_in(select_line_zero_in), .miso_oe(miso_oe), .main_control_register(main_control_register),
    .select_control_register(select_control_register), .rx_word(rx_word), .master_pins(master_pins),
    .status(status));
`default_nettype wire
